// >>> core/vic_prio_pkg.sv
// shared constants and types for the interrupt priority and nesting block
package vic_prio_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_VECTOR_TABLE_BASE = 32'hffff0014;
	localparam logic [31:0] ADDR_NORMAL_VECTOR_POINTER = 32'hffff001c;
	localparam logic [31:0] ADDR_PRIORITY_WORD_B = 32'hffff0024;
	localparam logic [31:0] ADDR_PRIORITY_WORD_C = 32'hffff0028;
	localparam logic [31:0] ADDR_NESTING_CONTROL = 32'hffff0030;
	localparam logic [31:0] ADDR_NORMAL_ACTIVE_PRIORITY_MASK = 32'hffff003c;
	localparam logic [31:0] ADDR_FAST_VECTOR_POINTER = 32'hffff011c;
	localparam logic [31:0] ADDR_FAST_ACTIVE_PRIORITY_MASK = 32'hffff013c;

	// writable bits of the priority words and nesting control, all others read zero
	localparam logic [31:0] WMASK_PRIORITY_WORD_B = 32'h77777777;
	localparam logic [31:0] WMASK_PRIORITY_WORD_C = 32'h00777777;
	localparam logic [31:0] WMASK_NESTING_CONTROL = 32'h00000003;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [1:0] RST_NEST = 2'h0;

	// nesting control fields
	localparam int NEST_NORMAL_BIT = 0;
	localparam int NEST_FAST_BIT = 1;

	// vector pointer layout
	localparam int VEC_BASE_LSB = 7;
	localparam int VEC_SRC_LSB = 2;
	localparam int BASE_W = 16;
	localparam int SRC_W = 5;
	localparam int PRIO_W = 3;
	localparam int LEVELS = 8;

	// source space and per-field placement
	localparam int NUM_SRC = 32;
	localparam int NUM_FIELDS = 14;
	localparam logic [PRIO_W-1:0] DEFAULT_PRIO = 3'h0;
	// source numbers for each field: word b fields 0..7, word c fields 8..13
	localparam logic [SRC_W-1:0] FIELD_SRC [NUM_FIELDS] = '{
		5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
	// low bit of each field inside its word
	localparam int FIELD_LSB [NUM_FIELDS] = '{
		0, 4, 8, 12, 16, 20, 24, 28,
		0, 4, 8, 12, 16, 20};
	localparam int FIELDS_IN_B = 8;

	// one arbitration result
	typedef struct packed {
		logic valid;
		logic [SRC_W-1:0] num;
		logic [PRIO_W-1:0] prio;
	} sel_t;

endpackage

// >>> core/vic_prio_nest.sv
// priority, nesting and vector logic of the interrupt controller, apb slave
//
// Summary of operation
// RULE1: priority word b holds a writable 0..7 supply monitor priority at bits 30:28.
// RULE2: word b holds comparator priority at 26:24 and external line 0 at 22:20.
// RULE3: word b holds serial port 18:16, two-wire b slave 14:12, b master 10:8, a slave 6:4, a master 2:0.
// RULE4: word c holds pwm 22:20, logic array 1 18:16, ext 3 14:12, ext 2 10:8, logic array 0 6:4, ext 1 2:0.
// RULE5: nesting control bit 0 turns on nesting and prioritisation of normal interrupts.
// RULE6: nesting control bit 1 turns on nesting and prioritisation of fast interrupts.
// RULE7: with nesting off both kinds still fire, levels are ignored and fast outranks normal.
// RULE8: reading the normal vector with nesting on sets the mask bit of the served priority.
// RULE9: a set mask bit blocks all interrupts of that priority and lower.
// RULE10: a mask write clears only the lowest set bit, one per write.
// RULE11: the fast vector reads zeros, the base at 22:7, the source at 6:2 and zeros at 1:0.
// RULE12: software reads the fast vector only while a fast interrupt is taken with nesting on.
// RULE13: the normal vector is formed like the fast one, with sources 0..21.
// RULE14: the vector base is a 16-bit writable field reset to zero, upper bits read zero.
// RULE15: reading the fast vector with fast nesting on sets a bit of a separate fast mask.
// RULE16: the lowest priority number wins, ties go to the lowest source, blocked winners raise nothing.
// RULE17: reserved bits read zero and ignore writes, everything resets to zero.
`timescale 1ns/1ps
module vic_prio_nest
	import vic_prio_pkg::*;
#(
	parameter int NORMAL_SRC = 22,
	parameter int FAST_SRC = 28
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NORMAL_SRC-1:0] normal_src_pending,
	input wire logic [FAST_SRC-1:0] fast_src_pending,
	output logic normal_req,
	output logic fast_req
);

	// software visible state
	logic [31:0] priority_word_b_reg;
	logic [31:0] priority_word_c_reg;
	logic [1:0] nesting_control_reg;
	logic [BASE_W-1:0] vector_table_base_reg;
	logic [LEVELS-1:0] normal_mask_reg;
	logic [LEVELS-1:0] fast_mask_reg;

	// bus answer and request state
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic normal_req_reg;
	logic fast_req_reg;

	// vector read captured at setup so value and mask side effect agree
	sel_t rd_sel_reg;
	logic rd_normal_vec_reg;
	logic rd_fast_vec_reg;

	logic [NUM_SRC*PRIO_W-1:0] src_prio;
	logic [NUM_SRC-1:0] normal_pend_ext;
	logic [NUM_SRC-1:0] fast_pend_ext;
	sel_t normal_sel;
	sel_t fast_sel;
	logic normal_nest;
	logic fast_nest;
	logic normal_blocked;
	logic fast_blocked;
	logic setup_phase;
	logic access_done;
	logic wr_done;
	logic [31:0] rd_value;
	logic rd_error;
	logic fast_win;
	logic wr_word_b;
	logic wr_word_c;
	logic wr_nest;
	logic wr_base;
	logic wr_normal_mask;
	logic wr_fast_mask;

	assign normal_nest = nesting_control_reg[NEST_NORMAL_BIT]; // RULE5
	assign fast_nest = nesting_control_reg[NEST_FAST_BIT]; // RULE6

	// pick the winning pending source
	function automatic sel_t pick(
		input logic [NUM_SRC-1:0] pend,
		input logic [NUM_SRC*PRIO_W-1:0] pr,
		input logic nest
	);
		sel_t best;
		best = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i] && (!best.valid || (nest && pr[i*PRIO_W +: PRIO_W] < best.prio))) begin
				best.valid = 1'b1; // RULE16
				best.num = SRC_W'(i);
				best.prio = pr[i*PRIO_W +: PRIO_W];
			end
		end
		return best;
	endfunction

	// true when any mask bit at or above the given level's urgency is set
	function automatic logic is_blocked(
		input logic [LEVELS-1:0] mask,
		input logic [PRIO_W-1:0] prio
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < LEVELS; i++) begin
			if (mask[i] && PRIO_W'(i) <= prio) begin
				hit = 1'b1; // RULE9
			end
		end
		return hit;
	endfunction

	// clear only the lowest set bit
	function automatic logic [LEVELS-1:0] clear_lowest(input logic [LEVELS-1:0] mask);
		return mask & (mask - LEVELS'(1)); // RULE10
	endfunction

	// per-source priority table, unmapped sources take the default level
	generate
		for (genvar s = 0; s < NUM_SRC; s++) begin : g_src_prio
			logic [PRIO_W-1:0] p;
			always_comb begin
				p = DEFAULT_PRIO;
				for (int f = 0; f < NUM_FIELDS; f++) begin
					if (FIELD_SRC[f] == SRC_W'(s)) begin
						if (f < FIELDS_IN_B) begin
							p = priority_word_b_reg[FIELD_LSB[f] +: PRIO_W]; // RULE1 RULE2 RULE3
						end else begin
							p = priority_word_c_reg[FIELD_LSB[f] +: PRIO_W]; // RULE4
						end
					end
				end
			end
			assign src_prio[s*PRIO_W +: PRIO_W] = p;
		end
	endgenerate

	// widen pending vectors to the common source space
	assign normal_pend_ext = NUM_SRC'(normal_src_pending);
	assign fast_pend_ext = NUM_SRC'(fast_src_pending);

	// arbitration for both kinds
	assign normal_sel = pick(normal_pend_ext, src_prio, normal_nest); // RULE16
	assign fast_sel = pick(fast_pend_ext, src_prio, fast_nest); // RULE16

	// blocking only applies while nesting is on
	assign normal_blocked = normal_nest && is_blocked(normal_mask_reg, normal_sel.prio); // RULE9
	assign fast_blocked = fast_nest && is_blocked(fast_mask_reg, fast_sel.prio); // RULE15

	// an unblocked fast winner also holds back the normal request
	assign fast_win = fast_sel.valid && !fast_blocked; // RULE7

	// apb phase decode
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign wr_done = access_done && pwrite && !pslverr_reg;

	// one write strobe per writable register, none for the two vector pointers, taken at the access-completing edge
	assign wr_word_b = wr_done && paddr == ADDR_PRIORITY_WORD_B;
	assign wr_word_c = wr_done && paddr == ADDR_PRIORITY_WORD_C;
	assign wr_nest = wr_done && paddr == ADDR_NESTING_CONTROL;
	assign wr_base = wr_done && paddr == ADDR_VECTOR_TABLE_BASE;
	assign wr_normal_mask = wr_done && paddr == ADDR_NORMAL_ACTIVE_PRIORITY_MASK;
	assign wr_fast_mask = wr_done && paddr == ADDR_FAST_ACTIVE_PRIORITY_MASK;

	// read value and address check, evaluated in the setup cycle
	always_comb begin
		rd_value = 32'h00000000;
		rd_error = 1'b0;
		if (paddr == ADDR_VECTOR_TABLE_BASE) begin
			rd_value = 32'(vector_table_base_reg); // RULE14
		end else if (paddr == ADDR_NORMAL_VECTOR_POINTER) begin
			rd_value = (32'(vector_table_base_reg) << VEC_BASE_LSB)
				| (32'(normal_sel.num) << VEC_SRC_LSB); // RULE13
		end else if (paddr == ADDR_PRIORITY_WORD_B) begin
			rd_value = priority_word_b_reg;
		end else if (paddr == ADDR_PRIORITY_WORD_C) begin
			rd_value = priority_word_c_reg;
		end else if (paddr == ADDR_NESTING_CONTROL) begin
			rd_value = 32'(nesting_control_reg); // RULE17
		end else if (paddr == ADDR_NORMAL_ACTIVE_PRIORITY_MASK) begin
			rd_value = 32'(normal_mask_reg);
		end else if (paddr == ADDR_FAST_VECTOR_POINTER) begin
			rd_value = (32'(vector_table_base_reg) << VEC_BASE_LSB)
				| (32'(fast_sel.num) << VEC_SRC_LSB); // RULE11
		end else if (paddr == ADDR_FAST_ACTIVE_PRIORITY_MASK) begin
			rd_value = 32'(fast_mask_reg);
		end else begin
			rd_error = 1'b1;
		end
	end

	// ready pulse: one wait-free access phase after each setup cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready_reg <= 1'b0;
		end else if (setup_phase) begin
			pready_reg <= 1'b1;
		end else if (access_done) begin
			pready_reg <= 1'b0;
		end
	end

	// error flag for unmapped addresses, shown with ready
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= rd_error; // RULE17
		end else if (access_done) begin
			pslverr_reg <= 1'b0;
		end
	end

	// read data, zero outside the access phase and for writes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= RST_WORD;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? RST_WORD : rd_value;
		end else if (access_done) begin
			prdata_reg <= RST_WORD;
		end
	end

	// remember which vector is being read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_normal_vec_reg <= 1'b0;
			rd_fast_vec_reg <= 1'b0;
		end else if (setup_phase) begin
			rd_normal_vec_reg <= !pwrite && paddr == ADDR_NORMAL_VECTOR_POINTER;
			rd_fast_vec_reg <= !pwrite && paddr == ADDR_FAST_VECTOR_POINTER;
		end
	end

	// winner of that read, so returned number and mask bit agree
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_sel_reg <= '0;
		end else if (setup_phase) begin
			rd_sel_reg <= (paddr == ADDR_FAST_VECTOR_POINTER) ? fast_sel : normal_sel;
		end
	end

	// priority word b, reserved bits masked off
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			priority_word_b_reg <= RST_WORD; // RULE17
		end else if (wr_word_b) begin
			priority_word_b_reg <= pwdata & WMASK_PRIORITY_WORD_B; // RULE1 RULE2 RULE3 RULE17
		end
	end

	// priority word c, reserved bits masked off
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			priority_word_c_reg <= RST_WORD;
		end else if (wr_word_c) begin
			priority_word_c_reg <= pwdata & WMASK_PRIORITY_WORD_C; // RULE4 RULE17
		end
	end

	// nesting control, two live bits
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			nesting_control_reg <= RST_NEST;
		end else if (wr_nest) begin
			nesting_control_reg <= 2'(pwdata & WMASK_NESTING_CONTROL); // RULE5 RULE6
		end
	end

	// vector table base, upper half never stored
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vector_table_base_reg <= RST_BASE;
		end else if (wr_base) begin
			vector_table_base_reg <= pwdata[BASE_W-1:0]; // RULE14
		end
	end

	// normal active mask: vector read sets, write clears lowest
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			normal_mask_reg <= RST_MASK;
		end else if (access_done && rd_normal_vec_reg && normal_nest && rd_sel_reg.valid) begin
			normal_mask_reg <= normal_mask_reg | (LEVELS'(1) << rd_sel_reg.prio); // RULE8
		end else if (wr_normal_mask) begin
			normal_mask_reg <= clear_lowest(normal_mask_reg); // RULE10
		end
	end

	// fast active mask, same behaviour as the normal one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fast_mask_reg <= RST_MASK;
		end else if (access_done && rd_fast_vec_reg && fast_nest && rd_sel_reg.valid) begin
			fast_mask_reg <= fast_mask_reg | (LEVELS'(1) << rd_sel_reg.prio); // RULE15
		end else if (wr_fast_mask) begin
			fast_mask_reg <= clear_lowest(fast_mask_reg); // RULE15
		end
	end

	// fast request to the core
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fast_req_reg <= 1'b0;
		end else begin
			fast_req_reg <= fast_win; // RULE16
		end
	end

	// normal request, held back while a fast one is raised
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			normal_req_reg <= 1'b0;
		end else begin
			normal_req_reg <= normal_sel.valid && !normal_blocked
				&& !fast_win; // RULE7
		end
	end

	// registered outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign normal_req = normal_req_reg;
	assign fast_req = fast_req_reg;

endmodule // vic_prio_nest

// >>> dv/vic_prio_nest_asserts.sv
// concurrent checks of bus timing and request rules of the priority block
`timescale 1ns/1ps
module vic_prio_nest_asserts
	import vic_prio_pkg::*;
#(
	parameter int NORMAL_SRC = 22,
	parameter int FAST_SRC = 28
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NORMAL_SRC-1:0] normal_src_pending,
	input wire logic [FAST_SRC-1:0] fast_src_pending,
	input wire logic normal_req,
	input wire logic fast_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [1:0] nest_reg;
	wire logic setup = psel && !penable;
	wire logic rd_done = psel && penable && pready && !pwrite;
	wire logic mapped = paddr inside {ADDR_VECTOR_TABLE_BASE, ADDR_NORMAL_VECTOR_POINTER,
		ADDR_PRIORITY_WORD_B, ADDR_PRIORITY_WORD_C, ADDR_NESTING_CONTROL,
		ADDR_NORMAL_ACTIVE_PRIORITY_MASK, ADDR_FAST_VECTOR_POINTER, ADDR_FAST_ACTIVE_PRIORITY_MASK};
	// shadow of the nesting bits, taken at the write edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			nest_reg <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == ADDR_NESTING_CONTROL)
			nest_reg <= pwdata[1:0];
	end
	chk_ready_pulse: assert property (setup |=> pready ##1 !pready)
		else $error("ready not a single pulse after setup");
	chk_ready_cause: assert property (pready |-> $past(setup))
		else $error("ready without setup");
	chk_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	chk_word_c_res: assert property (rd_done && paddr == ADDR_PRIORITY_WORD_C |->
		prdata[31:23] == 9'h0)
		else $error("reserved bits of word c set");
	chk_fvec_zero: assert property (rd_done && paddr == ADDR_FAST_VECTOR_POINTER |->
		prdata[31:23] == 9'h0 && prdata[1:0] == 2'h0)
		else $error("fast vector zero bits set");
	chk_fast_rank: assert property (fast_req |-> !normal_req)
		else $error("normal request beside fast");
	chk_fast_plain: assert property (!nest_reg[1] && |fast_src_pending |=> fast_req)
		else $error("fast request missing without nesting");
	chk_normal_plain: assert property (!nest_reg[0] && |normal_src_pending && !(|fast_src_pending)
		|=> normal_req)
		else $error("normal request missing without nesting");
	chk_fast_none: assert property (!(|fast_src_pending) |=> !fast_req)
		else $error("fast request without source");
	cov_fast: cover property (fast_req);
	cov_nested: cover property (nest_reg[0] && normal_req);
	cov_err: cover property (pslverr);
endmodule // vic_prio_nest_asserts

// >>> dv/core_model.sv
// model of the processor core taking interrupt requests
`timescale 1ns/1ps
module core_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic normal_req,
	input wire logic fast_req,
	output logic normal_entry,
	output logic fast_entry
);
	// enter the fast handler first, a normal one only without fast
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			normal_entry <= 1'b0;
			fast_entry <= 1'b0;
		end else begin
			fast_entry <= fast_req;
			normal_entry <= normal_req && !fast_req;
		end
	end
endmodule // core_model

// >>> dv/vic_prio_nest_tb_top.sv
// self-checking bench of the priority and nesting block
`timescale 1ns/1ps
module vic_prio_nest_tb_top;
	import vic_prio_pkg::*;
	localparam logic [31:0] AD [8] = '{ADDR_VECTOR_TABLE_BASE, ADDR_PRIORITY_WORD_B,
		ADDR_PRIORITY_WORD_C, ADDR_NESTING_CONTROL, ADDR_NORMAL_VECTOR_POINTER,
		ADDR_FAST_VECTOR_POINTER, ADDR_NORMAL_ACTIVE_PRIORITY_MASK, ADDR_FAST_ACTIVE_PRIORITY_MASK};
	localparam logic [31:0] WM [4] = '{32'h0000ffff, WMASK_PRIORITY_WORD_B,
		WMASK_PRIORITY_WORD_C, WMASK_NESTING_CONTROL};
	localparam logic [15:0] VB = 16'ha5c3;
	logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, v;
	logic pready, pslverr, normal_req, fast_req, normal_entry, fast_entry;
	logic [21:0] normal_src_pending = 0;
	logic [27:0] fast_src_pending = 0;
	logic [32:0] exp_q [$];
	logic [4:0] src;
	int num_errors = 0, cmp_count = 0, cyc = 0, seed = 86083, i;
	vic_prio_nest uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .normal_src_pending(normal_src_pending),
		.fast_src_pending(fast_src_pending), .normal_req(normal_req), .fast_req(fast_req));
	core_model core (.clk_sys(clk_sys), .nrst(nrst), .normal_req(normal_req),
		.fast_req(fast_req), .normal_entry(normal_entry), .fast_entry(fast_entry));
	initial forever #2.5 clk_sys = ~clk_sys;
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic er, input logic [31:0] d);
		exp_q.push_back({er, d});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cmp(input string n, input logic [32:0] x, input logic [32:0] g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic req(input logic f, input logic n);
		repeat (3) @(posedge clk_sys);
		cmp("requests", {31'h0, f, n}, {31'h0, fast_req, normal_req});
	endtask
	task automatic enter(input logic f);
		for (int k = 0; k < 20 && (f ? fast_entry : normal_entry) !== 1'b1; k++)
			@(posedge clk_sys);
		cmp("entry", 33'h1, {32'h0, f ? fast_entry : normal_entry});
	endtask
	task automatic complete_run;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// read monitor takes the oldest note
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite)
			cmp("read", exp_q.pop_front(), {pslverr, prdata});
	end
	// run limit
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		for (i = 0; i < 8; i++) rd(AD[i], 1'b0, 32'h0);
		rd(32'hffff0040, 1'b1, 32'h0);
		for (i = 0; i < 12; i++) begin
			v = $random(seed);
			apb(1'b1, AD[i % 4], v);
			rd(AD[i % 4], 1'b0, v & WM[i % 4]);
		end
		apb(1'b1, ADDR_VECTOR_TABLE_BASE, {16'hffff, VB});
		apb(1'b1, ADDR_NESTING_CONTROL, 32'h0);
		apb(1'b1, ADDR_NORMAL_VECTOR_POINTER, 32'hffffffff);
		rd(ADDR_NORMAL_VECTOR_POINTER, 1'b0, {9'h0, VB, 7'h0});
		// nesting off: fast first, levels ignored
		v = $random(seed);
		normal_src_pending <= (v[21:0] & 22'h3fff00) | 22'h200000;
		fast_src_pending <= 28'h10;
		req(1'b1, 1'b0);
		for (i = 21; i >= 8; i--) if (normal_src_pending[i]) src = i[4:0];
		fast_src_pending <= 28'h0;
		req(1'b0, 1'b1);
		rd(ADDR_NORMAL_VECTOR_POINTER, 1'b0, {9'h0, VB, src, 2'h0});
		rd(ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 1'b0, 32'h0);
		// normal nesting: levels, mask set, block and clear
		apb(1'b1, ADDR_PRIORITY_WORD_B, 32'h20000005);
		apb(1'b1, ADDR_PRIORITY_WORD_C, 32'h0);
		apb(1'b1, ADDR_NESTING_CONTROL, 32'h1);
		normal_src_pending <= 22'h8100;
		req(1'b0, 1'b1);
		enter(1'b0);
		rd(ADDR_NORMAL_VECTOR_POINTER, 1'b0, {9'h0, VB, 5'h0f, 2'h0});
		rd(ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 1'b0, 32'h4);
		req(1'b0, 1'b0);
		normal_src_pending <= 22'h100;
		req(1'b0, 1'b0);
		apb(1'b1, ADDR_PRIORITY_WORD_B, 32'h1);
		req(1'b0, 1'b1);
		rd(ADDR_NORMAL_VECTOR_POINTER, 1'b0, {9'h0, VB, 5'h08, 2'h0});
		rd(ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 1'b0, 32'h6);
		apb(1'b1, ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 32'hff);
		rd(ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 1'b0, 32'h4);
		apb(1'b1, ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 32'hff);
		rd(ADDR_NORMAL_ACTIVE_PRIORITY_MASK, 1'b0, 32'h0);
		// fast nesting through its own mask
		normal_src_pending <= 22'h0;
		apb(1'b1, ADDR_NESTING_CONTROL, 32'h3);
		fast_src_pending <= 28'h10;
		enter(1'b1);
		rd(ADDR_FAST_VECTOR_POINTER, 1'b0, {9'h0, VB, 5'h04, 2'h0});
		rd(ADDR_FAST_ACTIVE_PRIORITY_MASK, 1'b0, 32'h1);
		req(1'b0, 1'b0);
		apb(1'b1, ADDR_FAST_ACTIVE_PRIORITY_MASK, 32'hff);
		req(1'b1, 1'b0);
		repeat (2) @(posedge clk_sys);
		complete_run();
	end
endmodule // vic_prio_nest_tb_top
bind vic_prio_nest vic_prio_nest_asserts #(.NORMAL_SRC(NORMAL_SRC), .FAST_SRC(FAST_SRC)) chk (
	.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.normal_src_pending(normal_src_pending), .fast_src_pending(fast_src_pending),
	.normal_req(normal_req), .fast_req(fast_req));
